// File: rtl/aic_pipeline.sv
// per-channel correction pipeline with lockable configuration objects
`timescale 1ns/10ps
module aic_pipeline
import aic_pkg::*;
#(
    parameter int CH_BITS = 3
)
(
    input  wire logic               CORE_CLK,
    input  wire logic               RST,
    // raw converter sample, already filtered
    input  wire logic               SAMPLE_VALID,
    input  wire logic [CH_BITS-1:0] SAMPLE_CH,
    input  wire logic [15:0]        SAMPLE_RAW,
    input  wire logic [15:0]        SAMPLE_FILT,
    // object access port from the fieldbus side
    input  wire logic               OBJ_WR,
    input  wire logic               OBJ_RD,
    input  wire logic [CH_BITS-1:0] OBJ_CH,
    input  wire logic [7:0]         OBJ_IDX,
    input  wire logic [31:0]        OBJ_WDATA,
    output      logic [31:0]        OBJ_RDATA,
    output      logic               OBJ_RVALID,
    // corrected process data
    output      logic               PD_VALID,
    input  wire logic               PD_READY,
    output      logic [CH_BITS-1:0] PD_CH,
    output      logic [15:0]        PD_VALUE,
    output      logic               PD_UNDER,
    output      logic               PD_OVER,
    output      logic               PD_ERROR,
    output      logic [3:0]         FILTER_CODE,
    output      logic               SAMPLE_READY
);
    localparam int NCH = 1 << CH_BITS;
    localparam int BW  = CH_BITS + 19;

    // ------------------------------------------------------------
    // configuration store
    // ------------------------------------------------------------
    logic        en_scale_reg  [NCH], en_scale_next  [NCH];
    logic        en_ucal_reg   [NCH], en_ucal_next   [NCH];
    logic        en_vcal_reg   [NCH], en_vcal_next   [NCH];
    logic [15:0] sc_off_reg    [NCH], sc_off_next    [NCH];
    logic [31:0] sc_gain_reg   [NCH], sc_gain_next   [NCH];
    logic [15:0] cal_off_reg   [NCH], cal_off_next   [NCH];
    logic [15:0] cal_gain_reg  [NCH], cal_gain_next  [NCH];
    logic [15:0] itype_reg     [NCH], itype_next     [NCH];
    logic [15:0] scaler_reg    [NCH], scaler_next    [NCH];
    logic [31:0] lo_err_reg    [NCH], lo_err_next    [NCH];
    logic [31:0] hi_err_reg    [NCH], hi_err_next    [NCH];
    logic [15:0] raw_reg       [NCH], raw_next       [NCH];
    logic [15:0] filt_sel_reg,  filt_sel_next;
    logic        lock_reg,      lock_next;
    logic [31:0] restore_reg,   restore_next;

    // default threshold depends on the input type
    function automatic logic [31:0] low_default(input logic [15:0] t);
        if (t == TYPE_0_20)
            return 32'(-ONE_PCT);
        return 32'(LIVE_ZERO - ONE_PCT);
    endfunction : low_default

    // true for the four entries the lock protects
    function automatic logic is_protected(input logic [7:0] idx);
        return (idx == OBJ_CAL_OFFSET) || (idx == OBJ_CAL_GAIN) ||
               (idx == OBJ_LOW_RANGE_ERR) || (idx == OBJ_HIGH_RANGE_ERR);
    endfunction : is_protected

    logic wr_ok;
    logic do_restore;

    // ------------------------------------------------------------
    // object writes, lock and restore
    // ------------------------------------------------------------
    always_comb
    begin
        en_scale_next = en_scale_reg;
        en_ucal_next  = en_ucal_reg;
        en_vcal_next  = en_vcal_reg;
        sc_off_next   = sc_off_reg;
        sc_gain_next  = sc_gain_reg;
        cal_off_next  = cal_off_reg;
        cal_gain_next = cal_gain_reg;
        itype_next    = itype_reg;
        scaler_next   = scaler_reg;
        lo_err_next   = lo_err_reg;
        hi_err_next   = hi_err_reg;
        raw_next      = raw_reg;
        filt_sel_next = filt_sel_reg;
        lock_next     = lock_reg;
        restore_next  = restore_reg;
        // locked writes vanish with no error reply
        wr_ok      = OBJ_WR && !(lock_reg && is_protected(OBJ_IDX));
        do_restore = OBJ_WR && (OBJ_IDX == OBJ_RESTORE_TRIG) &&
                     (OBJ_WDATA == RESTORE_SIG);
        if (OBJ_WR && OBJ_IDX == OBJ_PROTECT)
        begin
            if (OBJ_WDATA == LOCK_ON_CODE)
                lock_next = 1'b1;
            else if (OBJ_WDATA == LOCK_OFF_CODE)
                lock_next = 1'b0;
        end
        if (OBJ_WR && OBJ_IDX == OBJ_RESTORE_TRIG)
            restore_next = OBJ_WDATA;
        if (do_restore)
        begin
            filt_sel_next = 16'h0000;
            for (int i = 0; i < NCH; i++)
            begin
                en_scale_next[i] = 1'b0;
                en_ucal_next[i]  = 1'b0;
                en_vcal_next[i]  = 1'b1;
                sc_off_next[i]   = 16'h0000;
                sc_gain_next[i]  = SCALE_GAIN_DEF;
                itype_next[i]    = TYPE_DEFAULT;
                scaler_next[i]   = SCALER_EXTENDED;
                // restore may not overwrite protected data
                if (!lock_reg)
                begin
                    cal_off_next[i]  = 16'h0000;
                    cal_gain_next[i] = CAL_GAIN_DEF;
                    lo_err_next[i]   = low_default(TYPE_DEFAULT);
                    hi_err_next[i]   = 32'(EXT_FULL + ONE_PCT);
                end
            end
        end
        else if (wr_ok)
        begin
            // vendor offset and gain have no write path
            case (OBJ_IDX)
                OBJ_EN_USER_SCALE:  en_scale_next[OBJ_CH] = OBJ_WDATA[0];
                OBJ_EN_USER_CAL:    en_ucal_next[OBJ_CH]  = OBJ_WDATA[0];
                OBJ_EN_VENDOR_CAL:  en_vcal_next[OBJ_CH]  = OBJ_WDATA[0];
                OBJ_SCALE_OFFSET:   sc_off_next[OBJ_CH]   = OBJ_WDATA[15:0];
                OBJ_SCALE_GAIN:
                begin
                    if ($signed(OBJ_WDATA) > $signed(SCALE_GAIN_LIM))
                        sc_gain_next[OBJ_CH] = SCALE_GAIN_LIM;
                    else if ($signed(OBJ_WDATA) < -$signed(SCALE_GAIN_LIM))
                        sc_gain_next[OBJ_CH] = 32'(-$signed(SCALE_GAIN_LIM));
                    else
                        sc_gain_next[OBJ_CH] = OBJ_WDATA;
                end
                OBJ_FILTER_SEL:
                begin
                    // only channel 0 steers the shared filter
                    if (OBJ_CH == '0 && OBJ_WDATA[15:0] <= FILTER_MAX)
                        filt_sel_next = OBJ_WDATA[15:0];
                end
                OBJ_CAL_OFFSET:     cal_off_next[OBJ_CH]  = OBJ_WDATA[15:0];
                OBJ_CAL_GAIN:       cal_gain_next[OBJ_CH] = OBJ_WDATA[15:0];
                OBJ_INPUT_TYPE:
                begin
                    if (OBJ_WDATA[15:0] == TYPE_0_20 ||
                        OBJ_WDATA[15:0] == TYPE_4_20 ||
                        OBJ_WDATA[15:0] == TYPE_NAMUR)
                        itype_next[OBJ_CH] = OBJ_WDATA[15:0];
                    // low default follows the type while the lock is off
                    if (!lock_reg && itype_next[OBJ_CH] != itype_reg[OBJ_CH])
                        lo_err_next[OBJ_CH] = low_default(itype_next[OBJ_CH]);
                end
                OBJ_SCALER:
                begin
                    // legacy is refused for the fault-signalling type
                    if (OBJ_WDATA[15:0] == SCALER_EXTENDED ||
                        (OBJ_WDATA[15:0] == SCALER_LEGACY &&
                         itype_reg[OBJ_CH] != TYPE_NAMUR))
                        scaler_next[OBJ_CH] = OBJ_WDATA[15:0];
                end
                OBJ_LOW_RANGE_ERR:  lo_err_next[OBJ_CH]   = OBJ_WDATA;
                OBJ_HIGH_RANGE_ERR: hi_err_next[OBJ_CH]   = OBJ_WDATA;
                default: ;
            endcase
        end
        // raw value kept for every sample taken while SAMPLE_READY is high
        if (SAMPLE_VALID && SAMPLE_READY)
            raw_next[SAMPLE_CH] = SAMPLE_RAW;
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                en_scale_reg[i] <= 1'b0;
                en_ucal_reg[i]  <= 1'b0;
                en_vcal_reg[i]  <= 1'b1;
                sc_off_reg[i]   <= 16'h0000;
                sc_gain_reg[i]  <= SCALE_GAIN_DEF;
                cal_off_reg[i]  <= 16'h0000;
                cal_gain_reg[i] <= CAL_GAIN_DEF;
                itype_reg[i]    <= TYPE_DEFAULT;
                scaler_reg[i]   <= SCALER_EXTENDED;
                lo_err_reg[i]   <= 32'(LIVE_ZERO - ONE_PCT);
                hi_err_reg[i]   <= 32'(EXT_FULL + ONE_PCT);
                raw_reg[i]      <= 16'h0000;
            end
            filt_sel_reg <= 16'h0000;
            lock_reg     <= 1'b0;
            restore_reg  <= 32'h00000000;
        end
        else
        begin
            en_scale_reg <= en_scale_next;
            en_ucal_reg  <= en_ucal_next;
            en_vcal_reg  <= en_vcal_next;
            sc_off_reg   <= sc_off_next;
            sc_gain_reg  <= sc_gain_next;
            cal_off_reg  <= cal_off_next;
            cal_gain_reg <= cal_gain_next;
            itype_reg    <= itype_next;
            scaler_reg   <= scaler_next;
            lo_err_reg   <= lo_err_next;
            hi_err_reg   <= hi_err_next;
            raw_reg      <= raw_next;
            filt_sel_reg <= filt_sel_next;
            lock_reg     <= lock_next;
            restore_reg  <= restore_next;
        end
    end

    // ------------------------------------------------------------
    // read path, one cycle latency
    // ------------------------------------------------------------
    logic [31:0] rdata_reg, rdata_next;
    logic        rvalid_reg, rvalid_next;

    always_comb
    begin
        rvalid_next = OBJ_RD;
        rdata_next  = rdata_reg;
        if (OBJ_RD)
        begin
            case (OBJ_IDX)
                OBJ_EN_USER_SCALE:  rdata_next = {31'h0, en_scale_reg[OBJ_CH]};
                OBJ_EN_USER_CAL:    rdata_next = {31'h0, en_ucal_reg[OBJ_CH]};
                OBJ_EN_VENDOR_CAL:  rdata_next = {31'h0, en_vcal_reg[OBJ_CH]};
                OBJ_SCALE_OFFSET:   rdata_next = {16'h0, sc_off_reg[OBJ_CH]};
                OBJ_SCALE_GAIN:     rdata_next = sc_gain_reg[OBJ_CH];
                OBJ_FILTER_SEL:     rdata_next = {16'h0, filt_sel_reg};
                OBJ_CAL_OFFSET:     rdata_next = {16'h0, cal_off_reg[OBJ_CH]};
                OBJ_CAL_GAIN:       rdata_next = {16'h0, cal_gain_reg[OBJ_CH]};
                OBJ_INPUT_TYPE:     rdata_next = {16'h0, itype_reg[OBJ_CH]};
                OBJ_SCALER:         rdata_next = {16'h0, scaler_reg[OBJ_CH]};
                OBJ_LOW_RANGE_ERR:  rdata_next = lo_err_reg[OBJ_CH];
                OBJ_HIGH_RANGE_ERR: rdata_next = hi_err_reg[OBJ_CH];
                OBJ_RAW_VALUE:      rdata_next = {16'h0, raw_reg[OBJ_CH]};
                OBJ_VENDOR_OFFSET:  rdata_next = {16'h0, VENDOR_OFF_DEF};
                OBJ_VENDOR_GAIN:    rdata_next = {16'h0, VENDOR_GAIN_DEF};
                OBJ_PROTECT:        rdata_next = {31'h0, lock_reg};
                OBJ_RESTORE_COUNT:  rdata_next = {24'h0, RESTORE_COUNT};
                OBJ_RESTORE_TRIG:   rdata_next = restore_reg;
                default:            rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            rdata_reg  <= 32'h00000000;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ------------------------------------------------------------
    // correction chain, one sample at a time
    // ------------------------------------------------------------
    logic signed [63:0] yh, ya, ys, yo;
    logic signed [31:0] lo_th, hi_th;
    logic               under, over;
    logic [15:0]        value;
    logic               buf_ready;

    always_comb
    begin
        // 64-bit intermediates so no stage can wrap
        yh = 64'($signed(SAMPLE_FILT));
        if (en_vcal_reg[SAMPLE_CH])
            yh = ((yh - 64'($signed(VENDOR_OFF_DEF))) *
                  64'($signed(VENDOR_GAIN_DEF))) >>> CAL_SHIFT;
        ya = yh;
        if (en_ucal_reg[SAMPLE_CH])
            ya = ((yh - 64'($signed(cal_off_reg[SAMPLE_CH]))) *
                  64'($signed(cal_gain_reg[SAMPLE_CH]))) >>> CAL_SHIFT;
        ys = ya;
        if (en_scale_reg[SAMPLE_CH])
            ys = ((ya * 64'($signed(sc_gain_reg[SAMPLE_CH]))) >>> SCALE_SHIFT)
                 + 64'($signed(sc_off_reg[SAMPLE_CH]));
        // map percent of full scale into the chosen range
        if (scaler_reg[SAMPLE_CH] == SCALER_LEGACY)
            yo = ys;
        else
            yo = (ys * 64'(EXT_FULL)) / 64'(LEG_FULL);
        lo_th = $signed(lo_err_reg[SAMPLE_CH]);
        hi_th = $signed(hi_err_reg[SAMPLE_CH]);
        under = yo < 64'(lo_th);
        over  = yo > 64'(hi_th);
        if (yo > 64'(S16_MAX))
            value = 16'h7FFF;
        else if (yo < 64'(S16_MIN))
            value = 16'h8000;
        else
            value = yo[15:0];
        // the 0-20 mA range never reports below zero
        if (itype_reg[SAMPLE_CH] == TYPE_0_20 && yo < 0)
            value = 16'h0000;
    end

    // ------------------------------------------------------------
    // output buffer and registered flags
    // ------------------------------------------------------------
    logic                 ob_valid;
    logic [CH_BITS+18:0]  ob_data;

    aic_buffer #(.WIDTH(CH_BITS + 19)) u_buf
    (
        .clk       (CORE_CLK),
        .rst       (RST),
        .in_valid  (SAMPLE_VALID),
        .in_ready  (buf_ready),
        .in_data   ({SAMPLE_CH, value, under || over, under, over}),
        .out_valid (ob_valid),
        .out_ready (PD_READY || !PD_VALID),
        .out_data  (ob_data)
    );

    logic              pdv_reg, pdv_next;
    logic [BW-1:0]     pd_reg, pd_next;
    logic              srdy_reg;
    logic [3:0]        fc_reg;

    always_comb
    begin
        pdv_next = pdv_reg;
        pd_next  = pd_reg;
        if (PD_READY || !pdv_reg)
        begin
            pdv_next = ob_valid;
            pd_next  = ob_data;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            pdv_reg  <= 1'b0;
            pd_reg   <= '0;
            srdy_reg <= 1'b0;
            fc_reg   <= 4'h0;
        end
        else
        begin
            pdv_reg  <= pdv_next;
            pd_reg   <= pd_next;
            srdy_reg <= buf_ready;
            fc_reg   <= filt_sel_next[3:0];
        end
    end

    assign PD_VALID     = pdv_reg;
    assign PD_CH        = pd_reg[CH_BITS+18:19];
    assign PD_VALUE     = pd_reg[18:3];
    assign PD_UNDER     = pd_reg[1];
    assign PD_OVER      = pd_reg[0];
    assign PD_ERROR     = pd_reg[2];
    assign OBJ_RDATA    = rdata_reg;
    assign OBJ_RVALID   = rvalid_reg;
    assign FILTER_CODE  = fc_reg;
    assign SAMPLE_READY = srdy_reg;

endmodule : aic_pipeline

// File: rtl/aic_pkg.sv
// constants shared by the analog input correction pipeline
package aic_pkg;

    // ------------------------------------------------------------
    // object indices (channel-relative sub-entries)
    // ------------------------------------------------------------
    localparam logic [7:0] OBJ_EN_USER_SCALE  = 8'h01;
    localparam logic [7:0] OBJ_EN_USER_CAL    = 8'h0A;
    localparam logic [7:0] OBJ_EN_VENDOR_CAL  = 8'h0B;
    localparam logic [7:0] OBJ_SCALE_OFFSET   = 8'h11;
    localparam logic [7:0] OBJ_SCALE_GAIN     = 8'h12;
    localparam logic [7:0] OBJ_FILTER_SEL     = 8'h15;
    localparam logic [7:0] OBJ_CAL_OFFSET     = 8'h17;
    localparam logic [7:0] OBJ_CAL_GAIN       = 8'h18;
    localparam logic [7:0] OBJ_INPUT_TYPE     = 8'h31;
    localparam logic [7:0] OBJ_SCALER         = 8'h32;
    localparam logic [7:0] OBJ_LOW_RANGE_ERR  = 8'h37;
    localparam logic [7:0] OBJ_HIGH_RANGE_ERR = 8'h38;
    localparam logic [7:0] OBJ_RAW_VALUE      = 8'h41;
    localparam logic [7:0] OBJ_VENDOR_OFFSET  = 8'h51;
    localparam logic [7:0] OBJ_VENDOR_GAIN    = 8'h52;
    localparam logic [7:0] OBJ_PROTECT        = 8'hF9;
    localparam logic [7:0] OBJ_RESTORE_COUNT  = 8'hE0;
    localparam logic [7:0] OBJ_RESTORE_TRIG   = 8'hE1;

    // ------------------------------------------------------------
    // codes and defaults
    // ------------------------------------------------------------
    localparam logic [31:0] LOCK_ON_CODE     = 32'h12345678;
    localparam logic [31:0] LOCK_OFF_CODE    = 32'h11223344;
    localparam logic [31:0] RESTORE_SIG      = 32'h64616F6C;
    localparam logic [7:0]  RESTORE_COUNT    = 8'h01;
    localparam logic [15:0] SCALER_EXTENDED  = 16'h0000;
    localparam logic [15:0] SCALER_LEGACY    = 16'h0003;
    localparam logic [15:0] TYPE_0_20        = 16'h0012;
    localparam logic [15:0] TYPE_4_20        = 16'h0013;
    localparam logic [15:0] TYPE_NAMUR       = 16'h0014;
    localparam logic [15:0] TYPE_DEFAULT     = 16'h0013;
    localparam logic [15:0] FILTER_MAX       = 16'h0009;
    localparam logic [15:0] CAL_GAIN_DEF     = 16'h4000;
    localparam logic [31:0] SCALE_GAIN_DEF   = 32'h00010000;
    localparam logic [31:0] SCALE_GAIN_LIM   = 32'h0007FFFF;
    localparam logic [15:0] VENDOR_GAIN_DEF  = 16'h4000;
    localparam logic [15:0] VENDOR_OFF_DEF   = 16'h0000;
    localparam int          CAL_SHIFT        = 14;
    localparam int          SCALE_SHIFT      = 16;
    // full scale in the extended range; 107 percent is 32654
    localparam logic signed [31:0] EXT_FULL  = 32'sh00007736;
    localparam logic signed [31:0] LEG_FULL  = 32'sh00007FFF;
    // raw data arrives normalised so that full scale is 32767
    localparam logic signed [31:0] ONE_PCT   = 32'sh00000148;
    localparam logic signed [31:0] LIVE_ZERO = 32'sh00001999;
    localparam logic signed [31:0] S16_MAX   = 32'sh00007FFF;
    localparam logic signed [31:0] S16_MIN   = -32'sh00008000;

endpackage : aic_pkg

// File: rtl/aic_buffer.sv
// two-entry valid/ready skid buffer for corrected samples
`timescale 1ns/10ps
module aic_buffer
#(
    parameter int WIDTH = 20
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic [1:0]       cnt_reg, cnt_next;
    logic             rd_reg, rd_next, wr_reg, wr_next;
    logic             push, pop;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        push     = in_valid && (cnt_reg != 2'd2);
        pop      = out_ready && (cnt_reg != 2'd0);
        mem_next = mem_reg;
        if (push)
            mem_next[wr_reg] = in_data;
        wr_next  = push ? ~wr_reg : wr_reg;
        rd_next  = pop ? ~rd_reg : rd_reg;
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            cnt_reg    <= 2'd0;
            rd_reg     <= 1'b0;
            wr_reg     <= 1'b0;
        end
        else
        begin
            mem_reg <= mem_next;
            cnt_reg <= cnt_next;
            rd_reg  <= rd_next;
            wr_reg  <= wr_next;
        end
    end

    // honest flags: full refuses, empty shows no data
    assign in_ready  = (cnt_reg != 2'd2);
    assign out_valid = (cnt_reg != 2'd0);
    assign out_data  = mem_reg[rd_reg];

endmodule : aic_buffer

// File: testbench/aic_pipeline_properties.sv
// concurrent checks on the correction pipeline ports
`timescale 1ns/10ps
module aic_pipeline_chk
import aic_pkg::*;
#(
    parameter int CH_BITS = 3
)
(
    input wire logic               CORE_CLK,
    input wire logic               RST,
    input wire logic               SAMPLE_VALID,
    input wire logic               SAMPLE_READY,
    input wire logic               OBJ_WR,
    input wire logic               OBJ_RD,
    input wire logic [CH_BITS-1:0] OBJ_CH,
    input wire logic [7:0]         OBJ_IDX,
    input wire logic [31:0]        OBJ_WDATA,
    input wire logic [31:0]        OBJ_RDATA,
    input wire logic               PD_VALID,
    input wire logic               PD_READY,
    input wire logic [15:0]        PD_VALUE,
    input wire logic               PD_UNDER,
    input wire logic               PD_OVER,
    input wire logic               PD_ERROR,
    input wire logic [3:0]         FILTER_CODE
);
    // one clock domain
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // a read one idle edge after a lock write shows the new state
    AST_LOCK_ON_READ: assert property (OBJ_RD && !OBJ_WR && OBJ_IDX == OBJ_PROTECT
        && $past(OBJ_WR && OBJ_IDX == OBJ_PROTECT
            && OBJ_WDATA == LOCK_ON_CODE, 2)
        |=> OBJ_RDATA == 32'h00000001) else $error("lock on not read back");
    AST_LOCK_OFF_READ: assert property (OBJ_RD && !OBJ_WR && OBJ_IDX == OBJ_PROTECT
        && $past(OBJ_WR && OBJ_IDX == OBJ_PROTECT
            && OBJ_WDATA == LOCK_OFF_CODE, 2)
        |=> OBJ_RDATA == 32'h00000000) else $error("lock off not read back");
    AST_VENDOR_FIXED: assert property (OBJ_RD && OBJ_IDX == OBJ_VENDOR_GAIN
        |=> OBJ_RDATA[15:0] == VENDOR_GAIN_DEF) else $error("vendor gain moved");
    AST_RESTORE_COUNT: assert property (OBJ_RD && OBJ_IDX == OBJ_RESTORE_COUNT
        |=> OBJ_RDATA[7:0] == RESTORE_COUNT) else $error("restore count wrong");
    AST_FILTER_OTHER_CH: assert property (OBJ_WR && OBJ_IDX == OBJ_FILTER_SEL
        && OBJ_CH != '0 |=> $stable(FILTER_CODE)) else $error("filter moved");
    AST_FILTER_CH0: assert property (OBJ_WR && OBJ_IDX == OBJ_FILTER_SEL
        && OBJ_CH == '0 && OBJ_WDATA <= 32'(FILTER_MAX)
        |=> FILTER_CODE == 4'($past(OBJ_WDATA))) else $error("filter not set");
    // a stalled word must stand still
    AST_PD_HOLD: assert property (PD_VALID && !PD_READY
        |=> PD_VALID && $stable(PD_VALUE)) else $error("word dropped in stall");
    AST_PD_LATENCY: assert property (SAMPLE_VALID && SAMPLE_READY
        |-> ##[1:3] PD_VALID) else $error("sample produced no word");
    AST_ERROR_BIT: assert property (PD_VALID
        |-> PD_ERROR == (PD_UNDER || PD_OVER)) else $error("error bit wrong");
    COV_STALL: cover property (PD_VALID && !PD_READY ##1 PD_READY);
    COV_UNDER: cover property (PD_VALID && PD_UNDER);
    COV_LOCK: cover property (OBJ_WR && OBJ_WDATA == LOCK_ON_CODE);
endmodule : aic_pipeline_chk
bind aic_pipeline aic_pipeline_chk #(.CH_BITS(CH_BITS)) u_aic_pipeline_chk (.*);

// File: testbench/pd_sink.sv
// process data sink standing in for the fieldbus master
`timescale 1ns/10ps
module pd_sink
(
    input  wire logic        clk,
    input  wire logic        stall,
    input  wire logic        valid,
    output      logic        ready,
    input  wire logic [15:0] value,
    input  wire logic        under
);
    logic [16:0] got_q[$];
    // the bench reads the queue
    assign ready = !stall;
    always @(posedge clk)
        if (valid && ready)
            got_q.push_back({under, value});
endmodule : pd_sink

// File: testbench/aic_pipeline_tb_top.sv
// self-checking bench for the correction pipeline
`timescale 1ns/10ps
module aic_pipeline_tb_top
import aic_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, s_valid = 1'b0, s_ready, stall = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, pd_valid, pd_ready, pd_under;
    logic [2:0]  s_ch = 3'h0, o_ch = 3'h0;
    logic [15:0] s_raw = 16'hA5C3, s_filt = 16'h0000, pd_value;
    logic [7:0]  idx = 8'h00;
    logic [3:0]  fc;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [16:0] w;
    int          bad_count = 0, total_checks = 0;
    aic_pipeline #(.CH_BITS(3)) u_aic_pipeline (.CORE_CLK(clk), .RST(rst),
        .SAMPLE_VALID(s_valid), .SAMPLE_CH(s_ch), .SAMPLE_RAW(s_raw),
        .SAMPLE_FILT(s_filt), .OBJ_WR(wr), .OBJ_RD(rd), .OBJ_CH(o_ch),
        .OBJ_IDX(idx), .OBJ_WDATA(wdata), .OBJ_RDATA(rdata), .OBJ_RVALID(),
        .PD_VALID(pd_valid), .PD_READY(pd_ready), .PD_CH(), .PD_VALUE(pd_value),
        .PD_UNDER(pd_under), .PD_OVER(), .PD_ERROR(), .FILTER_CODE(fc),
        .SAMPLE_READY(s_ready));
    pd_sink u_pd_sink (.clk(clk), .stall(stall), .valid(pd_valid),
        .ready(pd_ready), .value(pd_value), .under(pd_under));
    always #12.5 clk = ~clk;
    // inputs move 1 ns after the edge
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic put(input logic [7:0] i, input logic [31:0] v);
        idx = i;
        wdata = v;
        wr = 1'b1;
        tick;
        wr = 1'b0;
        tick;
    endtask : put
    task automatic get(input logic [7:0] i);
        idx = i;
        rd = 1'b1;
        tick;
        rd = 1'b0;
        d = rdata;
        tick;
    endtask : get
    // the trailing tick spaces samples
    task automatic feed(input logic [15:0] f);
        for (int n = 0; n < 50 && s_ready !== 1'b1; n++) tick;
        s_filt = f;
        s_valid = 1'b1;
        tick;
        s_valid = 1'b0;
        tick;
    endtask : feed
    task automatic take;
        for (int n = 0; n < 50 && u_pd_sink.got_q.size() == 0; n++) tick;
        w = (u_pd_sink.got_q.size() > 0) ? u_pd_sink.got_q.pop_front() : 'x;
    endtask : take
    task automatic t_lock;
        get(OBJ_PROTECT); chk(d, 32'h0);
        put(OBJ_CAL_OFFSET, 32'hA);
        put(OBJ_PROTECT, LOCK_ON_CODE);
        get(OBJ_PROTECT); chk(d, 32'h1);
        put(OBJ_CAL_OFFSET, 32'h55);
        put(OBJ_LOW_RANGE_ERR, 32'h20);
        put(OBJ_SCALE_OFFSET, 32'h5);
        get(OBJ_CAL_OFFSET); chk(d, 32'hA);
        get(OBJ_LOW_RANGE_ERR); chk(d, 32'(LIVE_ZERO - ONE_PCT));
        get(OBJ_SCALE_OFFSET); chk(d, 32'h5);
        put(OBJ_RESTORE_TRIG, RESTORE_SIG);
        get(OBJ_CAL_OFFSET); chk(d, 32'hA);
        get(OBJ_SCALE_OFFSET); chk(d, 32'h0);
        put(OBJ_PROTECT, LOCK_OFF_CODE);
        get(OBJ_PROTECT); chk(d, 32'h0);
        put(OBJ_RESTORE_TRIG, RESTORE_SIG);
        get(OBJ_CAL_OFFSET); chk(d, 32'h0);
        get(OBJ_RESTORE_COUNT); chk(d, 32'h1);
    endtask : t_lock
    task automatic t_fixed;
        put(OBJ_VENDOR_GAIN, 32'h1234);
        get(OBJ_VENDOR_GAIN); chk(d[15:0], VENDOR_GAIN_DEF);
        put(OBJ_FILTER_SEL, 32'h5);
        o_ch = 3'h1;
        put(OBJ_FILTER_SEL, 32'h3);
        chk(fc, 4'h5);
        o_ch = 3'h0;
        feed(16'h7FFF); take; chk(w, {1'b0, 16'h7736});
        get(OBJ_RAW_VALUE); chk(d[15:0], 16'hA5C3);
    endtask : t_fixed
    task automatic t_chain;
        put(OBJ_SCALER, SCALER_LEGACY);
        feed(16'h7FFF); take; chk(w[15:0], 16'h7FFF);
        put(OBJ_EN_USER_CAL, 32'h1);
        put(OBJ_CAL_GAIN, 32'h2000);
        feed(16'h4000); take; chk(w[15:0], 16'h2000);
        put(OBJ_EN_USER_SCALE, 32'h1);
        put(OBJ_SCALE_GAIN, 32'h20000);
        put(OBJ_SCALE_OFFSET, 32'h5);
        feed(16'h4000); take; chk(w[15:0], 16'h4005);
        put(OBJ_EN_USER_CAL, 32'h0);
        feed(16'h4000); take; chk(w[15:0], 16'h7FFF);
        put(OBJ_RESTORE_TRIG, RESTORE_SIG);
    endtask : t_chain
    task automatic t_zero_stall;
        put(OBJ_INPUT_TYPE, {16'h0000, TYPE_0_20});
        feed(16'hF830); take; chk(w, {1'b1, 16'h0000});
        stall = 1'b1;
        feed(16'h7FFF);
        feed(16'h0000);
        chk(u_pd_sink.got_q.size(), 32'h0);
        stall = 1'b0;
        take; chk(w, {1'b0, 16'h7736});
        take; chk(w, {1'b0, 16'h0000});
    endtask : t_zero_stall
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        tick;
        t_lock;
        t_fixed;
        t_chain;
        t_zero_stall;
        summarize;
    end
    // a few hundred cycles suffice; 16000 cycles is a hang
    initial
    begin
        #400000;
        bad_count++;
        summarize;
    end
endmodule : aic_pipeline_tb_top
